// ### rtl/addr_data_matcher.sv
// combinational match decision of comparator B
`timescale 1ns/1ps
module addr_data_matcher
  import cmpb_qual_pkg::*;
(
  input wire logic cycle_valid_i,
  input wire logic cycle_read_i,
  input wire logic paged_access_flag_i,
  input wire logic [CORE_ADDR_W-1:0] core_addr_i,
  input wire logic [PAGE_INDEX_W-1:0] program_page_index_i,
  input wire logic [CORE_DATA_W-1:0] core_data_i,
  input wire logic [CPU_ADDR_W-1:0] compare_value_i,
  input wire logic full_mode_i,
  input wire logic rw_qualify_enable_a_i,
  input wire logic rw_match_value_a_i,
  input wire logic [7:0] cbx_i,
  output logic match_o
);
  logic rw_en;
  logic rw_val;
  logic rw_ok;
  logic page_ok;
  logic addr_ok;
  logic data_ok;
  logic [CORE_ADDR_W-1:0] eff_addr;

  always_comb
  begin
    // full modes borrow direction qualification from comparator A
    rw_en = full_mode_i ? rw_qualify_enable_a_i : cbx_i[RW_QUALIFY_ENABLE_B_POS];
    rw_val = full_mode_i ? rw_match_value_a_i : cbx_i[RW_MATCH_VALUE_B_POS];
    // value 1 selects reads, 0 writes; value unused when disabled
    rw_ok = !rw_en || (cycle_read_i == rw_val);
    page_ok = (paged_access_flag_i == cbx_i[PAGE_QUALIFY_SELECT_POS]);
    if (paged_access_flag_i)
    begin
      eff_addr = {program_page_index_i, core_addr_i[PAGE_OFFSET_W-1:0]};
    end
    else
    begin
      eff_addr = core_addr_i;
    end
    addr_ok = (eff_addr[CPU_ADDR_W] == cbx_i[EXT_ADDR_BIT16_POS]) &&
              (eff_addr[CPU_ADDR_W-1:0] == compare_value_i);
    data_ok = (core_data_i == compare_value_i[CORE_DATA_W-1:0]);
    if (!cycle_valid_i)
    begin
      match_o = 1'b0;
    end
    else if (full_mode_i)
    begin
      match_o = rw_ok && data_ok;
    end
    else
    begin
      match_o = rw_ok && page_ok && addr_ok;
    end
  end
endmodule : addr_data_matcher

// ### rtl/cmpb_qual_pkg.sv
// constants for the comparator B extension qualifier
package cmpb_qual_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] CBX_INDEX = 8'h09;
  localparam logic [7:0] CBX_BYTE_ADDR = 8'h24;
  localparam int BUS_ADDR_W = 8;
  localparam int BUS_DATA_W = 32;
  // ==========================================================
  // field positions
  localparam int RW_QUALIFY_ENABLE_B_POS = 7;
  localparam int RW_MATCH_VALUE_B_POS = 6;
  localparam int PAGE_QUALIFY_SELECT_POS = 5;
  localparam int EXT_ADDR_BIT16_POS = 0;
  // ==========================================================
  // reset value and masks
  localparam logic [7:0] CBX_RESET = 8'h00;
  localparam logic [7:0] CBX_IMPL_MASK = 8'he1;
  // ==========================================================
  // core bus shape
  localparam int CORE_ADDR_W = 17;
  localparam int CPU_ADDR_W = 16;
  localparam int PAGE_OFFSET_W = 14;
  localparam int PAGE_INDEX_W = 3;
  localparam int CORE_DATA_W = 8;
endpackage : cmpb_qual_pkg

// ### rtl/dbg_cmpb_qualifier.sv
// comparator B extension register, bus slave and registered match
`timescale 1ns/1ps
// Notes on behaviour
// - direction counts in comparator B match only when its enable bit is set
// - with direction on, value 0 matches writes, value 1 matches reads
// - direction value bit is ignored while direction enable is clear
// - full modes use comparator A direction enable and value instead
// - page select 1: match only paged cycles, address is page index plus low 14 bits
// - page select 0: match only unpaged cycles, using the plain 17-bit address
// - effective address bit 16 (page index bit 2 on paged cycles) must equal the stored extended bit
// - full modes ignore page select and extended bit, data is compared
// - resets clear the register, qualifying end-trace reset keeps bits 7,6,5,0
module dbg_cmpb_qualifier
  import cmpb_qual_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // ==========================================================
  // avalon-mm slave
  input wire logic [BUS_ADDR_W-1:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [BUS_DATA_W-1:0] WRITEDATA_I,
  output logic [BUS_DATA_W-1:0] READDATA_O,
  output logic WAITREQUEST_O,
  // ==========================================================
  // reset cause from the system
  input wire logic SYS_RESET_I,
  input wire logic END_TRACE_RESET_I,
  input wire logic DEBUG_MODULE_ENABLE_I,
  input wire logic TRIGGER_AT_BEGIN_I,
  // ==========================================================
  // core bus observation
  input wire logic CYCLE_VALID_I,
  input wire logic CYCLE_READ_I,
  input wire logic PAGED_ACCESS_FLAG_I,
  input wire logic [CORE_ADDR_W-1:0] CORE_ADDR_I,
  input wire logic [PAGE_INDEX_W-1:0] PROGRAM_PAGE_INDEX_I,
  input wire logic [CORE_DATA_W-1:0] CORE_DATA_I,
  // ==========================================================
  // neighbouring debug state
  input wire logic [CPU_ADDR_W-1:0] COMPARE_VALUE_I,
  input wire logic FULL_MODE_I,
  input wire logic RW_QUALIFY_ENABLE_A_I,
  input wire logic RW_MATCH_VALUE_A_I,
  // ==========================================================
  // results
  output logic MATCH_B_O,
  output logic [7:0] CBX_O
);

  logic [7:0] cbx_reg;
  logic [7:0] cbx_next;
  logic done_reg;
  logic [BUS_DATA_W-1:0] rdata_reg;
  logic match_reg;
  logic match_next;
  logic req;
  logic accept;
  logic keep_on_reset;

  function automatic logic hits_cbx(input logic [BUS_ADDR_W-1:0] a);
    hits_cbx = (a == CBX_BYTE_ADDR);
  endfunction : hits_cbx

  // ==========================================================
  // bus handshake: one wait cycle, answer on the second edge
  assign req = READ_I || WRITE_I;
  assign accept = req && done_reg;
  assign WAITREQUEST_O = req && !done_reg;
  assign READDATA_O = rdata_reg;

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= req && !done_reg;
    end
  end

  // read data captured in the wait cycle so it stands at the accept edge
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rdata_reg <= '0;
    end
    else if (READ_I && !done_reg)
    begin
      if (hits_cbx(ADDRESS_I))
      begin
        rdata_reg <= {24'h00_0000, cbx_reg & CBX_IMPL_MASK};
      end
      else
      begin
        rdata_reg <= '0;
      end
    end
  end

  // ==========================================================
  // extension register
  assign keep_on_reset = END_TRACE_RESET_I && DEBUG_MODULE_ENABLE_I && !TRIGGER_AT_BEGIN_I;

  always_comb
  begin
    cbx_next = cbx_reg;
    if (SYS_RESET_I)
    begin
      // a system reset outranks a write arriving in the same cycle
      cbx_next = keep_on_reset ? cbx_reg : CBX_RESET;
    end
    else if (accept && WRITE_I && hits_cbx(ADDRESS_I))
    begin
      cbx_next = WRITEDATA_I[7:0] & CBX_IMPL_MASK;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cbx_reg <= CBX_RESET;
    end
    else
    begin
      cbx_reg <= cbx_next;
    end
  end

  assign CBX_O = cbx_reg;

  // ==========================================================
  // match qualification
  addr_data_matcher u_matcher (
    .cycle_valid_i(CYCLE_VALID_I),
    .cycle_read_i(CYCLE_READ_I),
    .paged_access_flag_i(PAGED_ACCESS_FLAG_I),
    .core_addr_i(CORE_ADDR_I),
    .program_page_index_i(PROGRAM_PAGE_INDEX_I),
    .core_data_i(CORE_DATA_I),
    .compare_value_i(COMPARE_VALUE_I),
    .full_mode_i(FULL_MODE_I),
    .rw_qualify_enable_a_i(RW_QUALIFY_ENABLE_A_I),
    .rw_match_value_a_i(RW_MATCH_VALUE_A_I),
    .cbx_i(cbx_reg),
    .match_o(match_next)
  );

  // registered so the trigger logic sees a clean one-cycle-late flag
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      match_reg <= 1'b0;
    end
    else
    begin
      match_reg <= match_next;
    end
  end

  assign MATCH_B_O = match_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_rw_write_only: assert property (
    (CYCLE_VALID_I && !FULL_MODE_I && cbx_reg[RW_QUALIFY_ENABLE_B_POS]
     && !cbx_reg[RW_MATCH_VALUE_B_POS] && CYCLE_READ_I) |=> !MATCH_B_O)
    else $error("write-only qualification matched a read");

  a_rw_read_only: assert property (
    (CYCLE_VALID_I && !FULL_MODE_I && cbx_reg[RW_QUALIFY_ENABLE_B_POS]
     && cbx_reg[RW_MATCH_VALUE_B_POS] && !CYCLE_READ_I) |=> !MATCH_B_O)
    else $error("read-only qualification matched a write");

  a_rw_ignored_off: assert property (
    (CYCLE_VALID_I && !FULL_MODE_I && !cbx_reg[RW_QUALIFY_ENABLE_B_POS]
     && !cbx_reg[PAGE_QUALIFY_SELECT_POS] && !PAGED_ACCESS_FLAG_I
     && CORE_ADDR_I == {cbx_reg[EXT_ADDR_BIT16_POS], COMPARE_VALUE_I})
    |=> MATCH_B_O)
    else $error("linear match lost with direction qualification off");

  a_full_dir_a: assert property (
    (CYCLE_VALID_I && FULL_MODE_I && RW_QUALIFY_ENABLE_A_I
     && (CYCLE_READ_I != RW_MATCH_VALUE_A_I)) |=> !MATCH_B_O)
    else $error("full mode ignored comparator A direction");

  a_full_data_hit: assert property (
    (CYCLE_VALID_I && FULL_MODE_I && !RW_QUALIFY_ENABLE_A_I
     && CORE_DATA_I == COMPARE_VALUE_I[CORE_DATA_W-1:0]) |=> MATCH_B_O)
    else $error("full mode data match missed");

  a_page_needs_paged: assert property (
    (!FULL_MODE_I && cbx_reg[PAGE_QUALIFY_SELECT_POS] && !PAGED_ACCESS_FLAG_I)
    |=> !MATCH_B_O)
    else $error("page select matched an unpaged cycle");

  a_paged_addr_hit: assert property (
    (CYCLE_VALID_I && !FULL_MODE_I && cbx_reg[PAGE_QUALIFY_SELECT_POS]
     && PAGED_ACCESS_FLAG_I && !cbx_reg[RW_QUALIFY_ENABLE_B_POS]
     && {PROGRAM_PAGE_INDEX_I, CORE_ADDR_I[PAGE_OFFSET_W-1:0]}
        == {cbx_reg[EXT_ADDR_BIT16_POS], COMPARE_VALUE_I}) |=> MATCH_B_O)
    else $error("paged flash address match missed");

  a_linear_needs_unpaged: assert property (
    (!FULL_MODE_I && !cbx_reg[PAGE_QUALIFY_SELECT_POS] && PAGED_ACCESS_FLAG_I)
    |=> !MATCH_B_O)
    else $error("linear select matched a paged cycle");

  a_bit16_mismatch: assert property (
    (!FULL_MODE_I && !PAGED_ACCESS_FLAG_I
     && CORE_ADDR_I[CPU_ADDR_W] != cbx_reg[EXT_ADDR_BIT16_POS]) |=> !MATCH_B_O)
    else $error("bit 16 mismatch still matched");

  a_reset_clears: assert property (
    (SYS_RESET_I && !keep_on_reset) |=> (cbx_reg == CBX_RESET))
    else $error("system reset left extension bits set");

  a_end_trace_keeps: assert property (
    (SYS_RESET_I && keep_on_reset) |=> (cbx_reg == $past(cbx_reg)))
    else $error("qualifying end-trace reset changed the register");

  a_unimpl_read_zero: assert property (
    (READ_I && !WAITREQUEST_O) |-> (READDATA_O[4:1] == 4'h0 && cbx_reg[4:1] == 4'h0))
    else $error("unimplemented bits not zero");

  a_bus_one_wait: assert property (
    (req && WAITREQUEST_O) |=> (!WAITREQUEST_O || !req))
    else $error("bus answer later than one wait cycle");

  // ==========================================================
  // positive cases, then register, idle and bus checks: a broken qualifier that never matches fails here
  a_rw_read_hit: assert property (
    (CYCLE_VALID_I && !FULL_MODE_I && cbx_reg[RW_QUALIFY_ENABLE_B_POS]
     && cbx_reg[RW_MATCH_VALUE_B_POS] && CYCLE_READ_I
     && !cbx_reg[PAGE_QUALIFY_SELECT_POS] && !PAGED_ACCESS_FLAG_I
     && CORE_ADDR_I == {cbx_reg[EXT_ADDR_BIT16_POS], COMPARE_VALUE_I})
    |=> MATCH_B_O)
    else $error("read-only qualification missed a read");

  a_rw_write_hit: assert property (
    (CYCLE_VALID_I && !FULL_MODE_I && cbx_reg[RW_QUALIFY_ENABLE_B_POS]
     && !cbx_reg[RW_MATCH_VALUE_B_POS] && !CYCLE_READ_I
     && !cbx_reg[PAGE_QUALIFY_SELECT_POS] && !PAGED_ACCESS_FLAG_I
     && CORE_ADDR_I == {cbx_reg[EXT_ADDR_BIT16_POS], COMPARE_VALUE_I})
    |=> MATCH_B_O)
    else $error("write-only qualification missed a write");

  a_rw_value_ignored: assert property (
    (CYCLE_VALID_I && !FULL_MODE_I && !cbx_reg[RW_QUALIFY_ENABLE_B_POS]
     && (cbx_reg[RW_MATCH_VALUE_B_POS] != CYCLE_READ_I)
     && !cbx_reg[PAGE_QUALIFY_SELECT_POS] && !PAGED_ACCESS_FLAG_I
     && CORE_ADDR_I == {cbx_reg[EXT_ADDR_BIT16_POS], COMPARE_VALUE_I})
    |=> MATCH_B_O)
    else $error("direction value used while direction qualification off");

  a_full_skip_dir: assert property (
    (CYCLE_VALID_I && FULL_MODE_I && !RW_QUALIFY_ENABLE_A_I
     && cbx_reg[RW_QUALIFY_ENABLE_B_POS]
     && (CYCLE_READ_I != cbx_reg[RW_MATCH_VALUE_B_POS])
     && CORE_DATA_I == COMPARE_VALUE_I[CORE_DATA_W-1:0]) |=> MATCH_B_O)
    else $error("full mode used comparator B direction bits");

  a_full_skip_page: assert property (
    (CYCLE_VALID_I && FULL_MODE_I && !RW_QUALIFY_ENABLE_A_I
     && ((PAGED_ACCESS_FLAG_I != cbx_reg[PAGE_QUALIFY_SELECT_POS])
         || (CORE_ADDR_I[CPU_ADDR_W] != cbx_reg[EXT_ADDR_BIT16_POS]))
     && CORE_DATA_I == COMPARE_VALUE_I[CORE_DATA_W-1:0]) |=> MATCH_B_O)
    else $error("full mode still qualified by page or bit 16");

  a_write_lands: assert property (
    (accept && WRITE_I && hits_cbx(ADDRESS_I) && !SYS_RESET_I)
    |=> (cbx_reg == (8'($past(WRITEDATA_I)) & CBX_IMPL_MASK)))
    else $error("register write did not land masked");

  a_cbx_unimpl_zero: assert property (
    (CBX_O & ~CBX_IMPL_MASK) == 8'h00)
    else $error("unimplemented register bits set");

  a_idle_no_match: assert property (
    !CYCLE_VALID_I |=> !MATCH_B_O)
    else $error("match without a core bus cycle");

  a_read_high_zero: assert property (
    (READ_I && !WAITREQUEST_O) |-> (READDATA_O[BUS_DATA_W-1:8] == 24'h00_0000))
    else $error("read data upper bits not zero");

  a_wait_on_start: assert property (
    (req && !$past(req)) |-> WAITREQUEST_O)
    else $error("new request accepted without a wait cycle");

endmodule : dbg_cmpb_qualifier

// ### tb/core_bus_model.sv
// core bus model feeding the observation inputs of comparator B
`timescale 1ns/1ps
module core_bus_model
  import cmpb_qual_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic rd_i,
  input wire logic pg_i,
  input wire logic [CORE_ADDR_W-1:0] addr_i,
  input wire logic [PAGE_INDEX_W-1:0] page_i,
  input wire logic [CORE_DATA_W-1:0] data_i,
  output logic valid_o,
  output logic read_o,
  output logic paged_o,
  output logic [CORE_ADDR_W-1:0] addr_o,
  output logic [PAGE_INDEX_W-1:0] page_o,
  output logic [CORE_DATA_W-1:0] data_o
);
  // idle bus flips its lines so a stale value never passes for a cycle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      {valid_o, read_o, paged_o} <= 3'h0;
      {addr_o, page_o, data_o} <= '0;
    end
    else if (go_i)
    begin
      {valid_o, read_o, paged_o} <= {1'b1, rd_i, pg_i};
      {addr_o, page_o, data_o} <= {addr_i, page_i, data_i};
    end
    else
    begin
      {valid_o, read_o, paged_o} <= {1'b0, ~read_o, ~paged_o};
      {addr_o, page_o, data_o} <= {~addr_o, ~page_o, ~data_o};
    end
  end
endmodule : core_bus_model

// ### tb/dbg_cmpb_qualifier_bench.sv
// self-checking bench of the comparator B qualifier
`timescale 1ns/1ps
module dbg_cmpb_qualifier_bench
  import cmpb_qual_pkg::*;
;
  typedef struct {logic v; int due;} note_t;
  logic clk, rst_n, rd, wr, sys_rst, et_rst, dbg_en, trig_begin, full, rwa_en, rw_match_value_a, waitreq;
  logic go, c_rd, c_pg, valid, cyc_rd, paged, match;
  logic [BUS_ADDR_W-1:0] addr;
  logic [BUS_DATA_W-1:0] wdata, rdata, q;
  logic [CORE_ADDR_W-1:0] c_addr, core_addr;
  logic [PAGE_INDEX_W-1:0] c_page, page;
  logic [CORE_DATA_W-1:0] c_data, core_data;
  logic [CPU_ADDR_W-1:0] cmp;
  logic [7:0] cbx, shadow;
  int fail_count, tests_run, cyc_n;
  note_t notes[$];
  dbg_cmpb_qualifier uut (.CLK_I(clk), .RST_N_I(rst_n), .ADDRESS_I(addr), .READ_I(rd),
    .WRITE_I(wr), .WRITEDATA_I(wdata), .READDATA_O(rdata), .WAITREQUEST_O(waitreq),
    .SYS_RESET_I(sys_rst), .END_TRACE_RESET_I(et_rst), .DEBUG_MODULE_ENABLE_I(dbg_en),
    .TRIGGER_AT_BEGIN_I(trig_begin), .CYCLE_VALID_I(valid), .CYCLE_READ_I(cyc_rd),
    .PAGED_ACCESS_FLAG_I(paged), .CORE_ADDR_I(core_addr), .PROGRAM_PAGE_INDEX_I(page),
    .CORE_DATA_I(core_data), .COMPARE_VALUE_I(cmp), .FULL_MODE_I(full),
    .RW_QUALIFY_ENABLE_A_I(rwa_en), .RW_MATCH_VALUE_A_I(rw_match_value_a), .MATCH_B_O(match), .CBX_O(cbx));
  core_bus_model core (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .rd_i(c_rd), .pg_i(c_pg),
    .addr_i(c_addr), .page_i(c_page), .data_i(c_data), .valid_o(valid), .read_o(cyc_rd),
    .paged_o(paged), .addr_o(core_addr), .page_o(page), .data_o(core_data));
  // ==========================================================
  // checking and closing
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  // ==========================================================
  // avalon master, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ws;
    ws = 1'b1;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    // waitrequest and read data are taken at the rising edge only
    for (int n = 0; n < 16 && ws !== 1'b0; n++)
    begin
      @(posedge clk);
      ws = waitreq;
      q = rdata;
    end
    if (ws !== 1'b0)
    begin
      fail_count++;
      test_done();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  function automatic logic exp_match(logic [7:0] x, logic f, logic ae, logic av,
    logic [15:0] c, logic v, logic r, logic p, logic [16:0] a, logic [2:0] pi, logic [7:0] d);
    logic [16:0] e;
    e = p ? {pi, a[13:0]} : a;
    if (!v)
      return 1'b0;
    if (f)
      return (d == c[7:0]) && (!ae || r == av);
    return (!x[7] || r == x[6]) &&
           (p == x[5]) && (e[15:0] == c) && (e[16] == x[0]);
  endfunction : exp_match
  // ==========================================================
  // result watcher: match appears two edges after the model is driven
  always @(posedge clk)
  begin
    #1;
    cyc_n++;
    if (notes.size() > 0 && notes[0].due == cyc_n)
    begin
      chk("match", 32'(match), 32'(notes[0].v));
      void'(notes.pop_front());
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    logic vv, vr, vp, nf, ne, nr;
    logic [16:0] va;
    logic [2:0] vi;
    logic [7:0] vd, x;
    logic [15:0] nc;
    {rst_n, rd, wr, sys_rst, et_rst, dbg_en, trig_begin, full, rwa_en, rw_match_value_a} = '0;
    {go, c_rd, c_pg, addr, wdata, c_addr, c_page, c_data, cmp} = '0;
    void'($urandom(32'h9079fab0));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("cbx reset", {24'h0, cbx}, {24'h0, CBX_RESET});
    bus(1'b1, CBX_BYTE_ADDR, 32'hffffffff);
    chk("cbx", {24'h0, cbx}, 32'he1);
    bus(1'b0, CBX_BYTE_ADDR, 32'h0);
    chk("read", q, 32'he1);
    bus(1'b1, 8'h20, 32'h0);
    bus(1'b0, 8'h28, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("cbx kept", {24'h0, cbx}, 32'he1);
    $display("register test done");
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b1, CBX_BYTE_ADDR, 32'he1);
      {et_rst, dbg_en, trig_begin} <= k[2:0];
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk("sys reset", {24'h0, cbx}, (k == 6) ? 32'he1 : 32'h0);
      @(posedge clk);
    end
    // mid-run power-on style reset must clear a loaded register
    bus(1'b1, CBX_BYTE_ADDR, 32'he1);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("async reset", {24'h0, cbx}, {24'h0, CBX_RESET});
    chk("reset wait", {31'h0, waitreq}, 32'h0);
    chk("reset match", {31'h0, match}, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    $display("reset test done");
    shadow = 8'h00;
    for (int i = 0; i < 400; i++)
    begin
      if (i % 32 == 0)
      begin
        x = 8'($urandom);
        bus(1'b1, CBX_BYTE_ADDR, {24'h0, x});
        shadow = x & 8'he1;
      end
      {vr, vp, va, vi, vd, nc} = 46'({$urandom, $urandom});
      {ne, nr} = 2'($urandom);
      vv = ($urandom % 8) != 0;
      nf = ($urandom % 4) == 0;
      if ($urandom % 4 != 0)
      begin
        // full mode must ignore page and bit 16, so disturb them there when nr is set
        vp = shadow[5] ^ (nf & nr);
        va = {shadow[0] ^ (nf & nr), nc};
        vi = {shadow[0], nc[15:14]};
        vd = nc[7:0];
      end
      go <= vv;
      c_rd <= vr;
      c_pg <= vp;
      c_addr <= va;
      c_page <= vi;
      c_data <= vd;
      @(posedge clk);
      full <= nf;
      rwa_en <= ne;
      rw_match_value_a <= nr;
      cmp <= nc;
      notes.push_back('{exp_match(shadow, nf, ne, nr, nc, vv, vr, vp, va, vi, vd), cyc_n + 2});
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    chk("notes left", notes.size(), 32'h0);
    $display("match test done");
    test_done();
  end
endmodule : dbg_cmpb_qualifier_bench
